// ===== inc/cto_pkg.sv
// Constants, carriers and power state codes for the observation bus.
package cto_pkg;
	// Width of the observation bus.
	localparam int OBS_W = 85;
	// Register byte offsets on the Wishbone slave.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CHAN = 4'h8;
	// Control field positions and reset values.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_EP_BIT = 1;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam logic CTRL_EP_RST = 1'h1;
	// Legacy power state codes.
	localparam logic [3:0] LPC_RESET = 4'h0;
	localparam logic [3:0] LPC_ACTIVE = 4'h1;
	localparam logic [3:0] LPC_L1_IN0 = 4'h2;
	localparam logic [3:0] LPC_L1_IN1 = 4'h3;
	localparam logic [3:0] LPC_ACT_IN = 4'h4;
	localparam logic [3:0] LPC_ACT_WT = 4'h5;
	localparam logic [3:0] LPC_DEEP_IN0 = 4'h6;
	localparam logic [3:0] LPC_DEEP_IN1 = 4'h7;
	localparam logic [3:0] LPC_DEEP_RDY = 4'h8;
	// Legacy power states as the core's state machine holds them.
	typedef enum logic [3:0] {
		LPS_RESET, LPS_ACTIVE, LPS_L1_IN0, LPS_L1_IN1, LPS_ACT_IN,
		LPS_ACT_WT, LPS_DEEP_IN0, LPS_DEEP_IN1, LPS_DEEP_RDY
	} cto_lps_t;
	// Receive side sequencing and header capture.
	typedef struct packed {
		logic [23:0] req_id;
		logic [7:0] type_fmt;
		logic hdr_lo_vld;
		logic hdr_hi_vld;
		logic pay_vld;
		logic seq_strobe;
	} cto_rx_t;
	// Transmit side handshake between the two layers.
	typedef struct packed {
		logic tl_req;
		logic dl_ack;
		logic dl_data_req;
		logic nullify;
		logic [7:0] channel_arbitration_result;
		logic tx_strobe;
	} cto_tx_t;
	// Power management view.
	typedef struct packed {
		cto_lps_t legacy_power_state;
		logic pme_sent;
		logic pme_resent;
		logic inhibit_tx;
		logic [3:0] ltssm_req;
		logic [1:0] ltssm_evt;
		logic power_event_msg_dropped;
	} cto_pm_t;
	// Link, channel and physical error view.
	typedef struct packed {
		logic link_up;
		logic datalink_active;
		logic [6:0] channel_enable_mask;
		logic [7:0] channel_init_done;
		logic [1:0] phy_err;
	} cto_lnk_t;
endpackage

// ===== core/cto_obs_core.sv
// Observation bus packer with a small Wishbone control slave.
//
// Chosen here: register access over Wishbone and the register addresses.
module cto_obs_core
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire cto_pkg::cto_rx_t rx_i,
	input wire cto_pkg::cto_tx_t tx_i,
	input wire cto_pkg::cto_pm_t pm_i,
	input wire cto_pkg::cto_lnk_t lnk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [cto_pkg::OBS_W-1:0] obs_bus
);

	// Observation bus register; the only path to the pins.
	logic [cto_pkg::OBS_W-1:0] obs_ff;
	// Next value of the observation bus.
	logic [cto_pkg::OBS_W-1:0] nxt_obs;
	// Control: bus enable and endpoint mode.
	logic ctrl_en_ff;
	logic ctrl_ep_ff;
	// Wishbone answer registers.
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [31:0] nxt_rdat;
	// Power state code after mapping.
	logic [3:0] lps_code;

	// Named decode wires.
	wire rx_live;
	wire [23:0] id_field;
	wire bus_req;
	wire wr_ctrl;
	wire hit_ctrl;
	wire hit_stat;
	wire hit_chan;
	wire [31:0] ctrl_word;
	wire [31:0] stat_word;
	wire [31:0] chan_word;
	wire [1:0] ep_flags;
	wire drop_flag;

	// Receive fields only carry meaning in a strobe cycle, so they
	// are zeroed otherwise to make a stale value obvious to monitors.
	assign rx_live = rx_i.seq_strobe;

	// Header-first cycles reuse the top byte for type and format.
	assign id_field = rx_i.hdr_lo_vld ?
		{rx_i.type_fmt, rx_i.req_id[15:0]} :
		rx_i.req_id;

	// Power event flags exist only when the core is an endpoint.
	assign ep_flags = ctrl_ep_ff ?
		{pm_i.pme_resent, pm_i.pme_sent} : 2'h0;

	// Only a root port stores received power event messages.
	assign drop_flag = pm_i.power_event_msg_dropped & ~ctrl_ep_ff;

	// The state machine enum maps onto the printed codes; the code
	// 0110b was printed twice, so the wait state takes 0101b.
	always_comb
	begin
		case (pm_i.legacy_power_state)
			cto_pkg::LPS_RESET: lps_code = cto_pkg::LPC_RESET;
			cto_pkg::LPS_ACTIVE: lps_code = cto_pkg::LPC_ACTIVE;
			cto_pkg::LPS_L1_IN0: lps_code = cto_pkg::LPC_L1_IN0;
			cto_pkg::LPS_L1_IN1: lps_code = cto_pkg::LPC_L1_IN1;
			cto_pkg::LPS_ACT_IN: lps_code = cto_pkg::LPC_ACT_IN;
			cto_pkg::LPS_ACT_WT: lps_code = cto_pkg::LPC_ACT_WT;
			cto_pkg::LPS_DEEP_IN0: lps_code = cto_pkg::LPC_DEEP_IN0;
			cto_pkg::LPS_DEEP_IN1: lps_code = cto_pkg::LPC_DEEP_IN1;
			cto_pkg::LPS_DEEP_RDY: lps_code = cto_pkg::LPC_DEEP_RDY;
			default: lps_code = cto_pkg::LPC_RESET;
		endcase
	end

	// Assemble the whole bus. When software disables observation the
	// bus reads all zero; the core itself never sees this logic.
	always_comb
	begin
		nxt_obs = '0;
		if (ctrl_en_ff)
		begin
			if (rx_live)
			begin
				nxt_obs[0] = rx_i.hdr_lo_vld;
				nxt_obs[1] = rx_i.hdr_hi_vld;
				nxt_obs[2] = rx_i.pay_vld;
				nxt_obs[37:14] = id_field;
			end
			nxt_obs[38] = rx_i.seq_strobe;
			nxt_obs[39] = tx_i.tl_req;
			nxt_obs[40] = tx_i.dl_ack;
			nxt_obs[41] = tx_i.dl_data_req;
			nxt_obs[42] = tx_i.nullify;
			nxt_obs[50:43] = tx_i.channel_arbitration_result;
			nxt_obs[51] = tx_i.tx_strobe;
			nxt_obs[55:52] = lps_code;
			nxt_obs[57:56] = ep_flags;
			nxt_obs[58] = pm_i.inhibit_tx;
			nxt_obs[62:59] = pm_i.ltssm_req;
			nxt_obs[64:63] = pm_i.ltssm_evt;
			nxt_obs[65] = drop_flag;
			nxt_obs[66] = lnk_i.link_up;
			nxt_obs[67] = lnk_i.datalink_active;
			nxt_obs[74:68] = lnk_i.channel_enable_mask;
			nxt_obs[82:75] = lnk_i.channel_init_done;
			nxt_obs[84:83] = lnk_i.phy_err;
		end
	end

	// One register stage keeps the bus glitch free and off the core's
	// timing paths; monitors see everything one cycle late.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			obs_ff <= '0;
		else
			obs_ff <= nxt_obs;
	end

	// Wishbone decode: a new request is one not yet answered.
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign hit_ctrl = (wb_adr_i == cto_pkg::REG_CTRL);
	assign hit_stat = (wb_adr_i == cto_pkg::REG_STAT);
	assign hit_chan = (wb_adr_i == cto_pkg::REG_CHAN);
	assign wr_ctrl = bus_req & wb_we_i & hit_ctrl & wb_sel_i[0];

	// Read words; status reflects what the bus currently shows.
	assign ctrl_word = {30'h0, ctrl_ep_ff, ctrl_en_ff};
	assign stat_word = {24'h0, obs_ff[84:83], obs_ff[67:66],
		obs_ff[55:52]};
	assign chan_word = {16'h0, obs_ff[82:75], 1'h0, obs_ff[74:68]};

	// Unmapped addresses read as zero and ignore writes.
	always_comb
	begin
		if (hit_ctrl)
			nxt_rdat = ctrl_word;
		else if (hit_stat)
			nxt_rdat = stat_word;
		else if (hit_chan)
			nxt_rdat = chan_word;
		else
			nxt_rdat = 32'h0;
	end

	// Control register; only the low byte lane holds fields.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ctrl_en_ff <= cto_pkg::CTRL_EN_RST;
			ctrl_ep_ff <= cto_pkg::CTRL_EP_RST;
		end
		else if (wr_ctrl)
		begin
			ctrl_en_ff <= wb_dat_i[cto_pkg::CTRL_EN_BIT];
			ctrl_ep_ff <= wb_dat_i[cto_pkg::CTRL_EP_BIT];
		end
	end

	// Answer every request one cycle after it appears, then drop ack
	// for a cycle so a request released on the ack is not answered twice.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ack_ff <= 1'h0;
			rdat_ff <= 32'h0;
		end
		else
		begin
			ack_ff <= bus_req;
			if (bus_req)
				rdat_ff <= nxt_rdat;
		end
	end

	// Outputs straight from the registers.
	assign obs_bus = obs_ff;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// Checks on the packed bus one cycle after its inputs, and on the Wishbone ack.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_RX_ID: assert property (
		ctrl_en_ff && rx_i.seq_strobe && !rx_i.hdr_lo_vld
		|=> obs_bus[37:14] == $past(rx_i.req_id))
		else $error("Requester ID not on bus.");

	AST_RX_TYPE: assert property (
		ctrl_en_ff && rx_i.seq_strobe && rx_i.hdr_lo_vld
		|=> obs_bus[37:30] == $past(rx_i.type_fmt)
			&& obs_bus[0])
		else $error("Type and format not in top byte.");

	AST_RX_QUAL: assert property (
		!rx_i.seq_strobe |=> obs_bus[38:0] == 39'h0)
		else $error("Receive fields set without strobe.");

	AST_TX_HS: assert property (
		ctrl_en_ff |=> obs_bus[42:39] == $past({tx_i.nullify,
			tx_i.dl_data_req, tx_i.dl_ack, tx_i.tl_req}))
		else $error("Transmit handshake bits wrong.");

	AST_ARB: assert property (
		ctrl_en_ff |=> obs_bus[51:43] == $past({tx_i.tx_strobe,
			tx_i.channel_arbitration_result}))
		else $error("Arbitration or strobe bits wrong.");

	AST_PM_WAIT: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_ACT_WT
		|=> obs_bus[55:52] == 4'h5)
		else $error("Wait state code wrong.");

	AST_PM_DEEP: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_DEEP_RDY
		|=> obs_bus[55:52] == 4'h8)
		else $error("Deep ready code wrong.");

	AST_EP_ONLY: assert property (
		!ctrl_ep_ff |=> obs_bus[57:56] == 2'h0)
		else $error("Endpoint flags set in root mode.");

	AST_DROP: assert property (
		ctrl_en_ff && !ctrl_ep_ff && pm_i.power_event_msg_dropped
		|=> obs_bus[65])
		else $error("Dropped message not flagged.");

	AST_PM_REQ: assert property (
		ctrl_en_ff |=> obs_bus[64:58] == $past({pm_i.ltssm_evt,
			pm_i.ltssm_req, pm_i.inhibit_tx}))
		else $error("Power request bits wrong.");

	AST_LINK: assert property (
		ctrl_en_ff |=> obs_bus[67:66] ==
			$past({lnk_i.datalink_active, lnk_i.link_up}))
		else $error("Link state bits wrong.");

	AST_CHAN: assert property (
		ctrl_en_ff |=> obs_bus[84:68] == $past({lnk_i.phy_err,
			lnk_i.channel_init_done, lnk_i.channel_enable_mask}))
		else $error("Channel or error bits wrong.");

	AST_OFF: assert property (
		!ctrl_en_ff ##1 !ctrl_en_ff |-> obs_bus == '0 ##1 1'b1)
		else $error("Bus not quiet while disabled.");

	AST_WB_ACK: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Wishbone ack not a single pulse.");

	// Bits 13:3 belong to fields this block leaves out; they stay low.
	AST_RX_GAP: assert property (
		obs_bus[13:3] == 11'h0)
		else $error("Unused receive bits not zero.");

	// Sequencing valids travel with the strobe cycle they came in.
	AST_RX_SEQ: assert property (
		ctrl_en_ff && rx_i.seq_strobe |=> obs_bus[2:0] ==
			$past({rx_i.pay_vld, rx_i.hdr_hi_vld, rx_i.hdr_lo_vld}))
		else $error("Receive sequencing bits wrong.");

	// A header-first cycle must leave the low two bytes of the ID alone.
	AST_RX_LOW: assert property (
		ctrl_en_ff && rx_i.seq_strobe |=> obs_bus[29:14] ==
			$past(rx_i.req_id[15:0]))
		else $error("Low requester bytes wrong.");

	AST_RX_STB: assert property (
		ctrl_en_ff && rx_i.seq_strobe |=> obs_bus[38])
		else $error("Receive strobe not on bus.");

	// Transmit handshake bits, one check per bit so a swap is caught.
	AST_TX_REQ: assert property (
		ctrl_en_ff |=> obs_bus[39] == $past(tx_i.tl_req))
		else $error("Transmit request bit wrong.");

	AST_TX_ACK: assert property (
		ctrl_en_ff |=> obs_bus[40] == $past(tx_i.dl_ack))
		else $error("Transmit acknowledge bit wrong.");

	AST_TX_DREQ: assert property (
		ctrl_en_ff |=> obs_bus[41] == $past(tx_i.dl_data_req))
		else $error("Next data request bit wrong.");

	AST_TX_NULL: assert property (
		ctrl_en_ff |=> obs_bus[42] == $past(tx_i.nullify))
		else $error("Nullify bit wrong.");

	AST_TX_STB: assert property (
		ctrl_en_ff |=> obs_bus[51] == $past(tx_i.tx_strobe))
		else $error("Transmit strobe bit wrong.");

	// Every legacy power state lands on its own printed code.
	AST_PM_RST: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_RESET
		|=> obs_bus[55:52] == 4'h0)
		else $error("Reset state code wrong.");

	AST_PM_ACT: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_ACTIVE
		|=> obs_bus[55:52] == 4'h1)
		else $error("Active state code wrong.");

	AST_PM_L1A: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_L1_IN0
		|=> obs_bus[55:52] == 4'h2)
		else $error("First light sleep code wrong.");

	AST_PM_L1B: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_L1_IN1
		|=> obs_bus[55:52] == 4'h3)
		else $error("Second light sleep code wrong.");

	AST_PM_ENT: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_ACT_IN
		|=> obs_bus[55:52] == 4'h4)
		else $error("Active entry code wrong.");

	AST_PM_DP0: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_DEEP_IN0
		|=> obs_bus[55:52] == 4'h6)
		else $error("First deep sleep code wrong.");

	AST_PM_DP1: assert property (
		ctrl_en_ff && pm_i.legacy_power_state == cto_pkg::LPS_DEEP_IN1
		|=> obs_bus[55:52] == 4'h7)
		else $error("Second deep sleep code wrong.");

	// Endpoint flags pass through unchanged while in endpoint mode.
	AST_EP_SENT: assert property (
		ctrl_en_ff && ctrl_ep_ff |=> obs_bus[56] == $past(pm_i.pme_sent))
		else $error("Power event sent bit wrong.");

	AST_EP_RESENT: assert property (
		ctrl_en_ff && ctrl_ep_ff |=> obs_bus[57] == $past(pm_i.pme_resent))
		else $error("Power event resent bit wrong.");

	AST_DROP_EP: assert property (
		ctrl_ep_ff |=> !obs_bus[65])
		else $error("Drop flag set in endpoint mode.");

	AST_INHIBIT: assert property (
		ctrl_en_ff |=> obs_bus[58] == $past(pm_i.inhibit_tx))
		else $error("Transmit inhibit bit wrong.");

	AST_PM_EVT: assert property (
		ctrl_en_ff |=> obs_bus[64:63] == $past(pm_i.ltssm_evt))
		else $error("Low power event bits wrong.");

	// Link and channel fields, again bit group by bit group.
	AST_DATALINK_ACTIVE: assert property (
		ctrl_en_ff |=> obs_bus[67] == $past(lnk_i.datalink_active))
		else $error("Data link up bit wrong.");

	AST_CH_EN: assert property (
		ctrl_en_ff |=> obs_bus[74:68] == $past(lnk_i.channel_enable_mask))
		else $error("Channel enable bits wrong.");

	AST_PHY: assert property (
		ctrl_en_ff |=> obs_bus[84:83] == $past(lnk_i.phy_err))
		else $error("Physical error bits wrong.");

	// No request, no answer: a stray ack could repeat an access.
	AST_WB_IDLE: assert property (
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("Wishbone ack without request.");

	// Read data holds between requests so a slow master still sees it.
	AST_WB_HOLD: assert property (
		!bus_req |=> $stable(wb_dat_o))
		else $error("Read data changed without request.");

endmodule

// ===== bench/cto_dbg_mon.sv
// Debug-side monitor that samples the observation bus like user test logic.
module cto_dbg_mon
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [cto_pkg::OBS_W-1:0] obs_bus,
	output logic [23:0] cap_id_ff,
	output logic [31:0] cap_cnt_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	// Receive bits mean nothing without the strobe, so it gates every capture.
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			cap_cnt_ff <= 32'h0;
			cap_id_ff <= 24'h0;
		end
		else if (obs_bus[38])
		begin
			cap_cnt_ff <= cap_cnt_ff + 32'h1;
			cap_id_ff <= obs_bus[37:14];
		end
	end
endmodule

// ===== bench/pcie_core_test_observation_bus_tb.sv
// Self-checking bench for the observation bus packer.
`define CTO_CHK(a, b) begin cmp_count++; \
if ((a) !== (b)) begin n_mismatch++; \
$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module pcie_core_test_observation_bus_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	cto_pkg::cto_rx_t rx_i = '0;
	cto_pkg::cto_tx_t tx_i = '0;
	cto_pkg::cto_pm_t pm_i = '0;
	cto_pkg::cto_lnk_t lnk_i = '0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o;
	logic [84:0] obs_bus, e, e_rd;
	logic [23:0] last_id = '0;
	logic [23:0] cap_id;
	logic [31:0] cap_cnt;
	// Shadow control: the slave writes one edge before the ack is seen,
	// and the bus shows it one edge later, so ctl lines up as it is.
	logic [1:0] ctl = 2'h3;
	logic run = 1'b0, hold = 1'b0;
	logic [81:0] v = '0;
	logic [81:0] q[$];
	int n_mismatch = 0, cmp_count = 0, n_stb = 0, cyc_cnt = 0;
	always #5 sys_clk = ~sys_clk;
	cto_obs_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_i(rx_i),
		.tx_i(tx_i), .pm_i(pm_i), .lnk_i(lnk_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .obs_bus(obs_bus));
	cto_dbg_mon u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .obs_bus(obs_bus),
		.cap_id_ff(cap_id), .cap_cnt_ff(cap_cnt));
	// Expected bus for one input sample under a given control value.
	function automatic logic [84:0] f_exp(logic [81:0] x, logic [1:0] c);
		cto_pkg::cto_rx_t r;
		cto_pkg::cto_tx_t t;
		cto_pkg::cto_pm_t p;
		cto_pkg::cto_lnk_t l;
		logic [84:0] o;
		{r, t, p, l} = x;
		o = '0;
		if (r.seq_strobe)
		begin
			o[2:0] = {r.pay_vld, r.hdr_hi_vld, r.hdr_lo_vld};
			o[37:14] = r.req_id;
			if (r.hdr_lo_vld)
				o[37:30] = r.type_fmt;
			o[38] = 1'b1;
		end
		o[51:39] = {t.tx_strobe, t.channel_arbitration_result, t.nullify,
			t.dl_data_req, t.dl_ack, t.tl_req};
		o[65:52] = {p.power_event_msg_dropped & ~c[1], p.ltssm_evt,
			p.ltssm_req, p.inhibit_tx, p.pme_resent & c[1],
			p.pme_sent & c[1], p.legacy_power_state};
		o[84:66] = {l.phy_err, l.channel_init_done, l.channel_enable_mask,
			l.datalink_active, l.link_up};
		return c[0] ? o : 85'h0;
	endfunction
	// Driver pushes every sample, so the queue never loses alignment.
	always @(posedge sys_clk)
	begin
		if (run)
		begin
			if (!hold)
				v = {36'({$urandom, $urandom}), 13'($urandom),
					cto_pkg::cto_lps_t'($urandom_range(8)), 10'($urandom),
					19'($urandom)};
			{rx_i, tx_i, pm_i, lnk_i} <= v;
			q.push_back(v);
		end
	end
	// Watcher checks the sample taken one edge before the latest push.
	always @(negedge sys_clk)
	begin
		if (q.size() > 1)
		begin
			e = f_exp(q.pop_front(), ctl);
			n_stb += e[38];
			if (e[38])
				last_id = e[37:14];
			`CTO_CHK(obs_bus[13:0], e[13:0])
			`CTO_CHK(obs_bus[37:14], e[37:14])
			`CTO_CHK(obs_bus[38], e[38])
			`CTO_CHK(obs_bus[40:39], e[40:39])
			`CTO_CHK(obs_bus[42:41], e[42:41])
			`CTO_CHK(obs_bus[51:43], e[51:43])
			`CTO_CHK(obs_bus[55:52], e[55:52])
			`CTO_CHK(obs_bus[57:56], e[57:56])
			`CTO_CHK(obs_bus[62:58], e[62:58])
			`CTO_CHK(obs_bus[65:63], e[65:63])
			`CTO_CHK(obs_bus[67:66], e[67:66])
			`CTO_CHK(obs_bus[82:68], e[82:68])
			`CTO_CHK(obs_bus[84:83], e[84:83])
		end
	end
	// One classic cycle; held until ack is seen, released right after.
	task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
		{wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
		// No limit of its own; without an ack only the bench timeout ends this wait.
		do
		begin
			@(posedge sys_clk);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (we && a == cto_pkg::REG_CTRL && s[0])
			ctl <= d[1:0];
	endtask
	task automatic stop_test();
		$display("counts: compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// A hang past the expected few hundred cycles ends the run.
	always @(posedge sys_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 8000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	initial
	begin
		void'($urandom(32'hC4A2));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		repeat (300) @(posedge sys_clk);
		$display("test endpoint traffic done");
		wb(1'b1, cto_pkg::REG_CTRL, 4'hF, 32'h1);
		repeat (200) @(posedge sys_clk);
		$display("test root port traffic done");
		wb(1'b1, cto_pkg::REG_CTRL, 4'hE, 32'h0);
		wb(1'b1, 4'hC, 4'hF, 32'h0);
		repeat (50) @(posedge sys_clk);
		$display("test ignored writes done");
		hold <= 1'b1;
		repeat (3) @(posedge sys_clk);
		e_rd = f_exp(v, ctl);
		wb(1'b0, cto_pkg::REG_STAT, 4'hF, 32'h0);
		`CTO_CHK(rd, {24'h0, e_rd[84:83], e_rd[67:66], e_rd[55:52]})
		wb(1'b0, cto_pkg::REG_CHAN, 4'hF, 32'h0);
		`CTO_CHK(rd, {16'h0, e_rd[82:75], 1'b0, e_rd[74:68]})
		wb(1'b0, 4'hC, 4'hF, 32'h0);
		`CTO_CHK(rd, 32'h0)
		hold <= 1'b0;
		$display("test register reads done");
		wb(1'b1, cto_pkg::REG_CTRL, 4'h1, 32'h0);
		repeat (50) @(posedge sys_clk);
		$display("test disabled bus done");
		`CTO_CHK(cap_cnt, 32'(n_stb))
		`CTO_CHK(cap_id, last_id)
		stop_test();
	end
endmodule
